// *** rtl/stp_defines.vh ***
// shared offsets, field positions, reset values and timing counts of the
// shadow transfer and target queue logic; included by every design file
`ifndef STP_DEFINES_VH
`define STP_DEFINES_VH

// register offsets on the 7-bit host register address
`define STP_ADDR_GCONF     7'h00
`define STP_ADDR_START     7'h02
`define STP_ADDR_GEAR      7'h12
`define STP_ADDR_VELOCITY_LIMIT      7'h24
`define STP_ADDR_AMAX      7'h28
`define STP_ADDR_DMAX      7'h29
`define STP_ADDR_JERK1     7'h2d
`define STP_ADDR_JERK2     7'h2e
`define STP_ADDR_JERK3     7'h2f
`define STP_ADDR_JERK4     7'h30
`define STP_ADDR_PCOMP     7'h32
`define STP_ADDR_TARGET    7'h37
`define STP_ADDR_QUEUE0    7'h38
`define STP_ADDR_QUEUE7    7'h3f
`define STP_ADDR_BACKUP0   7'h40
`define STP_ADDR_BACKUP13  7'h4d

// counts of the shadowed ramp set, its two backup stages and the target queue
`define STP_RAMP_N         7
`define STP_BACKUP_N       14
`define STP_QUEUE_N        8

// start_setup field positions
`define STP_SHADOW_EN_BIT  4
`define STP_QEN_HI         15
`define STP_QEN_LO         12
`define STP_SHOPT_HI       17
`define STP_SHOPT_LO       16
`define STP_CYCLIC_BIT     18
`define STP_SKIP_HI        23
`define STP_SKIP_LO        20
`define STP_WBMASK_HI      31
`define STP_WBMASK_LO      24

// shadow option encodings handled here
`define STP_SHOPT_SINGLE   2'b00
`define STP_SHOPT_DOUBLE   2'b01

// first and last jerk entry of backup stage one, offset of stage two
`define STP_JERK_FIRST     4'd3
`define STP_JERK_LAST      4'd6
`define STP_STAGE2_OFS     4'd7

// conversion time of new jerk values, in clock cycles
`define STP_BOW_CONV_CYC   9'd320

// reset values
`define STP_RST_WORD       32'h0000_0000
`define STP_RST_SKIP       4'h0
`define STP_RST_CONV       9'h000

`endif

// *** rtl/stp_queue.v ***
// eight-stage parameter queue that splits into up to four segments
// assumes start_i is a one-cycle pulse and all inputs share clk_i
`timescale 1ns/10ps
`include "stp_defines.vh"

module stp_queue #(
    parameter DW = 32                        // data width of each stage
) (
    input  wire          clk_i,
    input  wire          reset_i,
    input  wire          start_i,            // internal start pulse
    input  wire [3:0]    queue_en_i,         // destination enables
    input  wire [7:0]    wb_mask_i,          // queue_writeback_mask
    input  wire          wr_i,               // host write of one stage
    input  wire [2:0]    wr_idx_i,
    input  wire [DW-1:0] wr_data_i,
    input  wire [2:0]    rd_idx_i,
    input  wire [DW-1:0] cur_target_i,       // present destination values
    input  wire [DW-1:0] cur_pcomp_i,
    input  wire [DW-1:0] cur_gear_i,
    input  wire [DW-1:0] cur_gconf_i,
    output wire [DW-1:0] rd_data_o,
    output wire [DW-1:0] load_target_o,      // value each destination takes
    output wire [DW-1:0] load_pcomp_o,
    output wire [DW-1:0] load_gear_o,
    output wire [DW-1:0] load_gconf_o
);

    reg [DW-1:0] stage_q [0:`STP_QUEUE_N-1]; // queue_stages
    reg [DW-1:0] wb_val  [0:`STP_QUEUE_N-1]; // write-back value per stage
    reg [2:0]    n_en;                       // number of destinations
    reg [1:0]    rk      [0:3];              // rank of each destination
    integer      s;
    integer      d;
    integer      t;                          // index of the clocked loops

    // segment that a stage belongs to, by number of destinations
    function [1:0] seg_of;
        input [2:0] st;
        input [2:0] n;
        begin
            case (n)
                3'd2:    seg_of = {1'b0, st[2]};
                3'd3:    seg_of = (st < 3'd3) ? 2'd0 :
                                  (st < 3'd6) ? 2'd1 : 2'd2;
                3'd4:    seg_of = st[2:1];
                default: seg_of = 2'd0;
            endcase
        end
    endfunction

    // first stage of a segment: 8, 4, 3+3+2 or 2 stages deep
    function [2:0] base_of;
        input [1:0] r;
        input [2:0] n;
        begin
            case (n)
                3'd2:    base_of = {r[0], 2'b00};
                3'd3:    base_of = (r == 2'd0) ? 3'd0 :
                                   (r == 2'd1) ? 3'd3 : 3'd6;
                3'd4:    base_of = {r, 1'b0};
                default: base_of = 3'd0;
            endcase
        end
    endfunction

    // ranks, segment count and write-back values
    always @* begin
        n_en  = {2'b00, queue_en_i[0]} + {2'b00, queue_en_i[1]} +
                {2'b00, queue_en_i[2]} + {2'b00, queue_en_i[3]};
        rk[0] = 2'd0;
        rk[1] = {1'b0, queue_en_i[0]};
        rk[2] = rk[1] + {1'b0, queue_en_i[1]};
        rk[3] = rk[2] + {1'b0, queue_en_i[2]};
        for (s = 0; s < `STP_QUEUE_N; s = s + 1) begin
            wb_val[s] = stage_q[s];
            for (d = 0; d < 4; d = d + 1) begin
                if (queue_en_i[d] && rk[d] == seg_of(s[2:0], n_en)) begin
                    case (d)
                        0:       wb_val[s] = cur_target_i;
                        1:       wb_val[s] = cur_pcomp_i;
                        2:       wb_val[s] = cur_gear_i;
                        default: wb_val[s] = cur_gconf_i;
                    endcase
                end
            end
        end
    end

    // shift on start; the last stage of a segment holds its value
    always @(posedge clk_i) begin
        if (reset_i) begin
            for (t = 0; t < `STP_QUEUE_N; t = t + 1)
                stage_q[t] <= `STP_RST_WORD;
        end else if (start_i && queue_en_i != 4'h0) begin
            for (t = 0; t < `STP_QUEUE_N; t = t + 1) begin
                if (wb_mask_i[t])
                    stage_q[t] <= wb_val[t];
                else if (t < `STP_QUEUE_N - 1 &&
                         seg_of(t[2:0], n_en) ==
                         seg_of(t[2:0] + 3'd1, n_en))
                    stage_q[t] <= stage_q[(t < 7) ? t + 1 : t];
            end
        end else if (wr_i) begin
            stage_q[wr_idx_i] <= wr_data_i;
        end
    end

    assign rd_data_o = stage_q[rd_idx_i];

    // each destination takes the head of its own segment
    assign load_target_o = stage_q[base_of(rk[0], n_en)];
    assign load_pcomp_o  = stage_q[base_of(rk[1], n_en)];
    assign load_gear_o   = stage_q[base_of(rk[2], n_en)];
    assign load_gconf_o  = stage_q[base_of(rk[3], n_en)];

endmodule // stp_queue

// *** rtl/stp_shadow_target.v ***
// shadow ramp parameter transfer and target queue register bank
// assumes the serial host port front end hands over decoded word writes
// and an internal start pulse, all on clk_i; reads are answered from the
// registered read bus one cycle after the address is presented
`timescale 1ns/10ps
`include "stp_defines.vh"

// Summary of operation
// - unshadowed ramp parameters keep host-written values
// - non-cyclic: last backup stage holds after transfer
// - skip configured starts, transfer on following one
// - running skip count reads at bits 23:20
// - no transfer within 320 cycles after jerk writes
// - start loads head, each stage takes successor
// - enable 0001 feeds target position only
// - masked stages take fed register's present value
// - queue 0x38..0x3F splits into up to four segments
// - enable bits map target, compare, gear, global
// - depth eight, four, three/three/two or two
// - compare from stage zero, gear from four
// - target zero, compare three, gear six
// - double option: stage one active, two to one
// - cyclic: previous active set written back
module stp_shadow_target #(
    parameter DW = 32                          // register width
) (
    input  wire          clk_i,
    input  wire          reset_i,
    input  wire [6:0]    reg_addr_i,           // word address
    input  wire [DW-1:0] reg_wdata_i,
    input  wire          reg_wr_i,             // one-cycle write strobe
    input  wire          start_i,              // internal start pulse
    output reg  [DW-1:0] reg_rdata_o,          // registered read data
    output reg  [DW-1:0] global_configuration_o,
    output reg  [DW-1:0] step_scaling_factor_o,
    output reg  [DW-1:0] position_compare_value_o,
    output reg  [DW-1:0] target_position_o,
    output wire [DW-1:0] velocity_limit_o,
    output wire [DW-1:0] accel_limit_o,
    output wire [DW-1:0] decel_limit_o,
    output wire [DW-1:0] jerk_first_o,
    output wire [DW-1:0] jerk_second_o,
    output wire [DW-1:0] jerk_third_o,
    output wire [DW-1:0] jerk_fourth_o,
    output reg           backup_load_strobe_o, // pulse per transfer
    output reg           bow_convert_busy_o    // jerk conversion running
);

    // register state
    reg  [DW-1:0] start_setup_q;               // stored start setup word
    reg  [DW-1:0] act_q [0:`STP_RAMP_N-1];     // active ramp set
    reg  [DW-1:0] bkp_q [0:`STP_BACKUP_N-1];   // backup_parameter_set
    reg  [3:0]    skip_cnt_q;                  // skipped_start_counter
    reg  [8:0]    conv_cnt_q;                  // jerk conversion timer
    reg  [DW-1:0] rdata_d;                     // next read data
    integer       i;

    // decoded configuration fields
    wire          shadow_en  = start_setup_q[`STP_SHADOW_EN_BIT];
    wire          cyclic     = start_setup_q[`STP_CYCLIC_BIT];
    wire [1:0]    sh_opt     = start_setup_q[`STP_SHOPT_HI:`STP_SHOPT_LO];
    wire [3:0]    queue_en   = start_setup_q[`STP_QEN_HI:`STP_QEN_LO];
    wire [3:0]    skip_limit = start_setup_q[`STP_SKIP_HI:`STP_SKIP_LO];
    wire [7:0]    wb_mask    =
                      start_setup_q[`STP_WBMASK_HI:`STP_WBMASK_LO];

    // address decode of the queue and backup windows
    wire          hit_queue  = reg_addr_i >= `STP_ADDR_QUEUE0 &&
                               reg_addr_i <= `STP_ADDR_QUEUE7;
    wire          hit_bkp    = reg_addr_i >= `STP_ADDR_BACKUP0 &&
                               reg_addr_i <= `STP_ADDR_BACKUP13;
    wire [6:0]    bkp_ofs    = reg_addr_i - `STP_ADDR_BACKUP0;
    wire [3:0]    bkp_idx    = bkp_ofs[3:0];
    wire [2:0]    queue_idx  = reg_addr_i[2:0];

    // a jerk entry of either backup stage restarts the conversion timer
    wire          jerk_in_s1 = bkp_idx >= `STP_JERK_FIRST &&
                               bkp_idx <= `STP_JERK_LAST;
    wire          jerk_in_s2 =
                      bkp_idx >= `STP_JERK_FIRST + `STP_STAGE2_OFS &&
                      bkp_idx <= `STP_JERK_LAST + `STP_STAGE2_OFS;
    wire          jerk_wr    = reg_wr_i && hit_bkp &&
                               (jerk_in_s1 || jerk_in_s2);
    wire          conv_busy  = bow_convert_busy_o;

    // a start counts toward a transfer only for the handled options and
    // only once the conversion of new jerk values has finished
    wire          start_sh   = start_i && shadow_en && !conv_busy &&
                               !sh_opt[1];
    wire          xfer       = start_sh &&
                               skip_cnt_q >= skip_limit;
    wire          skip       = start_sh && !xfer;

    // queue side
    wire          q_start    = start_i && queue_en != 4'h0;
    wire [DW-1:0] q_rdata;
    wire [DW-1:0] ld_target;
    wire [DW-1:0] ld_pcomp;
    wire [DW-1:0] ld_gear;
    wire [DW-1:0] ld_gconf;

    // index of the active ramp register at a given address
    function [3:0] ramp_idx;
        input [6:0] a;
        begin
            case (a)
                `STP_ADDR_VELOCITY_LIMIT:  ramp_idx = 4'd0;
                `STP_ADDR_AMAX:  ramp_idx = 4'd1;
                `STP_ADDR_DMAX:  ramp_idx = 4'd2;
                `STP_ADDR_JERK1: ramp_idx = 4'd3;
                `STP_ADDR_JERK2: ramp_idx = 4'd4;
                `STP_ADDR_JERK3: ramp_idx = 4'd5;
                `STP_ADDR_JERK4: ramp_idx = 4'd6;
                default:         ramp_idx = 4'hf;
            endcase
        end
    endfunction

    wire [3:0]    ridx       = ramp_idx(reg_addr_i);
    wire          hit_ramp   = ridx != 4'hf;

    // eight-stage queue feeding the four destinations
    stp_queue #(
        .DW            (DW)
    ) u_queue (
        .clk_i         (clk_i),
        .reset_i       (reset_i),
        .start_i       (start_i),
        .queue_en_i    (queue_en),
        .wb_mask_i     (wb_mask),
        .wr_i          (reg_wr_i && hit_queue),
        .wr_idx_i      (queue_idx),
        .wr_data_i     (reg_wdata_i),
        .rd_idx_i      (queue_idx),
        .cur_target_i  (target_position_o),
        .cur_pcomp_i   (position_compare_value_o),
        .cur_gear_i    (step_scaling_factor_o),
        .cur_gconf_i   (global_configuration_o),
        .rd_data_o     (q_rdata),
        .load_target_o (ld_target),
        .load_pcomp_o  (ld_pcomp),
        .load_gear_o   (ld_gear),
        .load_gconf_o  (ld_gconf)
    );

    // destinations: a queue load on start beats a host write, since
    // the start marks the moment at which the new value must apply
    always @(posedge clk_i) begin
        if (reset_i) begin
            target_position_o        <= `STP_RST_WORD;
            position_compare_value_o <= `STP_RST_WORD;
            step_scaling_factor_o    <= `STP_RST_WORD;
            global_configuration_o   <= `STP_RST_WORD;
            start_setup_q            <= `STP_RST_WORD;
        end else begin
            // target position, enable bit 0
            if (q_start && queue_en[0])
                target_position_o <= ld_target;
            else if (reg_wr_i && reg_addr_i == `STP_ADDR_TARGET)
                target_position_o <= reg_wdata_i;
            // compare position, enable bit 1
            if (q_start && queue_en[1])
                position_compare_value_o <= ld_pcomp;
            else if (reg_wr_i && reg_addr_i == `STP_ADDR_PCOMP)
                position_compare_value_o <= reg_wdata_i;
            // gear factor, enable bit 2
            if (q_start && queue_en[2])
                step_scaling_factor_o <= ld_gear;
            else if (reg_wr_i && reg_addr_i == `STP_ADDR_GEAR)
                step_scaling_factor_o <= reg_wdata_i;
            // global configuration, enable bit 3
            if (q_start && queue_en[3])
                global_configuration_o <= ld_gconf;
            else if (reg_wr_i && reg_addr_i == `STP_ADDR_GCONF)
                global_configuration_o <= reg_wdata_i;
            // start setup is plain host storage
            if (reg_wr_i && reg_addr_i == `STP_ADDR_START)
                start_setup_q <= reg_wdata_i;
        end
    end

    // active ramp set and both backup stages; a transfer beats a host
    // write of the same cycle so that one start moves a coherent set
    always @(posedge clk_i) begin
        if (reset_i) begin
            for (i = 0; i < `STP_RAMP_N; i = i + 1)
                act_q[i] <= `STP_RST_WORD;
            for (i = 0; i < `STP_BACKUP_N; i = i + 1)
                bkp_q[i] <= `STP_RST_WORD;
        end else if (xfer) begin
            for (i = 0; i < `STP_RAMP_N; i = i + 1) begin
                // stage one becomes the active ramp set
                act_q[i] <= bkp_q[i];
                if (sh_opt == `STP_SHOPT_DOUBLE) begin
                    // stage two moves up into stage one
                    bkp_q[i] <= bkp_q[i + `STP_RAMP_N];
                    if (cyclic)
                        bkp_q[i + `STP_RAMP_N] <= act_q[i];
                    // otherwise stage two keeps its contents
                end else if (cyclic) begin
                    // single level swaps active and backup sets
                    bkp_q[i] <= act_q[i];
                end
                // single level, non-cyclic: backups hold
            end
        end else if (reg_wr_i) begin
            // parameters outside a transfer change only here
            if (hit_ramp)
                act_q[ridx[2:0]] <= reg_wdata_i;
            if (hit_bkp)
                bkp_q[bkp_idx] <= reg_wdata_i;
        end
    end

    // skipped-start counter and jerk conversion timer
    always @(posedge clk_i) begin
        if (reset_i) begin
            skip_cnt_q           <= `STP_RST_SKIP;
            conv_cnt_q           <= `STP_RST_CONV;
            backup_load_strobe_o <= 1'b0;
            bow_convert_busy_o   <= 1'b0;
        end else begin
            if (xfer)
                skip_cnt_q <= `STP_RST_SKIP;
            else if (skip)
                skip_cnt_q <= skip_cnt_q + 4'd1;
            // a new jerk write restarts the full conversion time
            if (jerk_wr)
                conv_cnt_q <= `STP_BOW_CONV_CYC;
            else if (conv_busy)
                conv_cnt_q <= conv_cnt_q - 9'd1;
            backup_load_strobe_o <= xfer;
            bow_convert_busy_o   <= jerk_wr || conv_cnt_q > 9'd1;
        end
    end

    // read mux; the skip field shows the running count, not the limit
    always @* begin
        rdata_d = `STP_RST_WORD;
        if (hit_queue)
            rdata_d = q_rdata;
        else if (hit_bkp)
            rdata_d = bkp_q[bkp_idx];
        else if (hit_ramp)
            rdata_d = act_q[ridx[2:0]];
        else begin
            case (reg_addr_i)
                `STP_ADDR_GCONF:  rdata_d = global_configuration_o;
                `STP_ADDR_GEAR:   rdata_d = step_scaling_factor_o;
                `STP_ADDR_PCOMP:  rdata_d = position_compare_value_o;
                `STP_ADDR_TARGET: rdata_d = target_position_o;
                `STP_ADDR_START: begin
                    rdata_d = start_setup_q;
                    rdata_d[`STP_SKIP_HI:`STP_SKIP_LO] =
                        skip_cnt_q;
                end
                default:          rdata_d = `STP_RST_WORD;
            endcase
        end
    end

    // registered read bus
    always @(posedge clk_i) begin
        if (reset_i)
            reg_rdata_o <= `STP_RST_WORD;
        else
            reg_rdata_o <= rdata_d;
    end

    // ramp outputs come straight from the active set flops
    assign velocity_limit_o   = act_q[0];
    assign accel_limit_o      = act_q[1];
    assign decel_limit_o      = act_q[2];
    assign jerk_first_o       = act_q[3];
    assign jerk_second_o      = act_q[4];
    assign jerk_third_o       = act_q[5];
    assign jerk_fourth_o      = act_q[6];

endmodule // stp_shadow_target

// *** sim/stp_host_model.sv ***
// host side model: word writes, reads and internal start pulses
// assumes the bench calls its tasks; drives on falling edges only
`timescale 1ns/10ps

module stp_host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] reg_rdata_i,
    output logic      [6:0]  reg_addr_o,
    output logic      [31:0] reg_wdata_o,
    output logic             reg_wr_o,
    output logic             start_o
);
    // idle on an unmapped address so stray reads show as zero
    initial begin
        reg_addr_o = 7'h7f;
        reg_wdata_o = 32'h0000_0000;
        reg_wr_o = 1'b0;
        start_o = 1'b0;
    end
    // one word write; released data flips so it is never reused
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
    // read data is registered, so it is taken one cycle later
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
    // starts come at standstill only, no steady-velocity wait needed
    task automatic pulse_start();
        @(negedge clk_i);
        start_o = 1'b1;
        @(negedge clk_i);
        start_o = 1'b0;
    endtask
    // wait out the jerk conversion before asking for a transfer
    task automatic settle();
        repeat (330) @(negedge clk_i);
    endtask
endmodule // stp_host_model

// *** sim/stp_shadow_target_asserts.sv ***
// port checker for the shadow transfer and target queue bank
// assumes it is bound onto stp_shadow_target, single clock domain
`timescale 1ns/10ps
`include "stp_defines.vh"

module stp_shadow_target_asserts (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic [6:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        start_i,
    input wire logic [31:0] step_scaling_factor_o,
    input wire logic [31:0] target_position_o,
    input wire logic [31:0] velocity_limit_o,
    input wire logic [31:0] jerk_first_o,
    input wire logic        backup_load_strobe_o,
    input wire logic        bow_convert_busy_o
);
    // host writes that may legally move an output
    wire logic tgt_wr = reg_wr_i && reg_addr_i == `STP_ADDR_TARGET;
    wire logic gear_wr = reg_wr_i && reg_addr_i == `STP_ADDR_GEAR;
    wire logic vel_wr = reg_wr_i && reg_addr_i == `STP_ADDR_VELOCITY_LIMIT;
    wire logic j1_wr = reg_wr_i && reg_addr_i == `STP_ADDR_JERK1;
    // jerk entries of both backup stages restart the conversion
    wire logic jerk_wr = reg_wr_i &&
        ((reg_addr_i >= 7'h43 && reg_addr_i <= 7'h46) ||
         (reg_addr_i >= 7'h4a && reg_addr_i <= 7'h4d));
    logic [8:0] busy_cnt_q; // busy cycles since the last jerk write

    // counts how long the conversion has run, a stuck timer shows here
    always_ff @(posedge clk_i) begin
        if (reset_i || jerk_wr) busy_cnt_q <= 9'h000;
        else if (bow_convert_busy_o) busy_cnt_q <= busy_cnt_q + 9'h001;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_strobe_cause;
        backup_load_strobe_o |-> $past(start_i);
    endproperty
    a_strobe_cause: assert property (p_strobe_cause)
        else $error("transfer strobe without a start");
    property p_no_xfer_busy;
        backup_load_strobe_o |-> !$past(bow_convert_busy_o);
    endproperty
    a_no_xfer_busy: assert property (p_no_xfer_busy)
        else $error("transfer during jerk conversion");
    property p_busy_after_jerk;
        jerk_wr |=> bow_convert_busy_o [*8];
    endproperty
    a_busy_after_jerk: assert property (p_busy_after_jerk)
        else $error("jerk write did not start conversion");
    property p_busy_bound;
        busy_cnt_q <= 9'd320;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("conversion longer than 320 cycles");
    property p_target_cause;
        $changed(target_position_o) |->
            $past(start_i) || $past(tgt_wr) || $past(reset_i);
    endproperty
    a_target_cause: assert property (p_target_cause)
        else $error("target moved without start or write");
    property p_gear_cause;
        $changed(step_scaling_factor_o) |->
            $past(start_i) || $past(gear_wr) || $past(reset_i);
    endproperty
    a_gear_cause: assert property (p_gear_cause)
        else $error("gear moved without start or write");
    property p_vel_cause;
        $changed(velocity_limit_o) |->
            backup_load_strobe_o || $past(vel_wr) || $past(reset_i);
    endproperty
    a_vel_cause: assert property (p_vel_cause)
        else $error("velocity limit moved without cause");
    property p_jerk_cause;
        $changed(jerk_first_o) |->
            backup_load_strobe_o || $past(j1_wr) || $past(reset_i);
    endproperty
    a_jerk_cause: assert property (p_jerk_cause)
        else $error("first jerk moved without cause");
endmodule // stp_shadow_target_asserts

bind stp_shadow_target stp_shadow_target_asserts u_chk (
    .clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .start_i,
    .step_scaling_factor_o, .target_position_o, .velocity_limit_o,
    .jerk_first_o, .backup_load_strobe_o, .bow_convert_busy_o
);

// *** sim/stp_shadow_target_tb.sv ***
// self-checking bench of the shadow transfer and target queue bank
// assumes stp_host_model drives the host side
`timescale 1ns/10ps
`include "stp_defines.vh"

module stp_shadow_target_tb;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [6:0]  addr;
    logic        wr, start, strobe, busy;
    logic [31:0] wdata, rdata, gconf, gear, pcomp, tgt, vel, jerk1, rv, j4;
    int          bad_count = 0;
    int          n_checks = 0;
    // source stage per destination {gconf,gear,pcomp,target}, f = none
    logic [15:0] qmap [16] = '{16'hffff, 16'hfff0, 16'hff0f, 16'hff40,
        16'hf0ff, 16'hf4f0, 16'hf40f, 16'hf630, 16'h0fff, 16'h4ff0,
        16'h4f0f, 16'h6f30, 16'h40ff, 16'h63f0, 16'h630f, 16'h6420};

    always #2 clk_i = ~clk_i;

    stp_host_model hm (.clk_i(clk_i), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
        .start_o(start));
    stp_shadow_target #(.DW(32)) uut (.clk_i(clk_i), .reset_i(reset_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .start_i(start), .reg_rdata_o(rdata),
        .global_configuration_o(gconf), .step_scaling_factor_o(gear),
        .position_compare_value_o(pcomp), .target_position_o(tgt),
        .velocity_limit_o(vel), .accel_limit_o(), .decel_limit_o(),
        .jerk_first_o(jerk1), .jerk_second_o(), .jerk_third_o(),
        .jerk_fourth_o(j4), .backup_load_strobe_o(strobe),
        .bow_convert_busy_o(busy));

    task automatic chk(input string nm, input logic [31:0] e, got);
        n_checks++;
        if (got !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, got);
            bad_count++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // single target queue, stage four rewritten with the old target
    task automatic t_queue_target();
        hm.wr(`STP_ADDR_TARGET, 32'h55);
        hm.wr(`STP_ADDR_START, 32'h1000_1000);
        for (int i = 0; i < 8; i++) hm.wr(7'h38 + 7'(i), 32'ha0 + 32'(i));
        hm.pulse_start();
        chk("target", 32'ha0, tgt);
        for (int i = 0; i < 8; i++) begin
            hm.rd(7'h38 + 7'(i), rv);
            chk("stage", (i == 4) ? 32'h55 : 32'ha1 + 32'((i == 7) ? 6 : i), rv);
        end
        $display("queue target done");
    endtask
    // every enable pattern against the source stage table
    task automatic t_queue_map();
        logic [31:0] old [4];
        logic [31:0] now [4];
        logic [3:0]  ix;
        for (int e = 0; e < 16; e++) begin
            hm.wr(`STP_ADDR_START, {16'h0, 4'(e), 12'h0});
            for (int i = 0; i < 8; i++)
                hm.wr(7'h38 + 7'(i), {8'hc0, 8'(e), 16'(i)});
            old = '{tgt, pcomp, gear, gconf};
            hm.pulse_start();
            now = '{tgt, pcomp, gear, gconf};
            for (int d = 0; d < 4; d++) begin
                ix = qmap[e][4*d +: 4];
                chk("dest", (ix == 4'hf) ? old[d] : {8'hc0, 8'(e), 16'(ix)}, now[d]);
            end
        end
        $display("queue map done");
    endtask
    // double stage, skip two, start during conversion dropped
    task automatic t_shadow_double();
        hm.wr(`STP_ADDR_VELOCITY_LIMIT, 32'h100);
        hm.wr(`STP_ADDR_GCONF, 32'h77);
        hm.wr(`STP_ADDR_START, 32'h0021_0010);
        for (int i = 0; i < 14; i++) hm.wr(7'h40 + 7'(i), 32'h200 + 32'(i));
        hm.pulse_start();
        hm.rd(`STP_ADDR_START, rv);
        chk("skip_cnt", 32'h0, {28'h0, rv[23:20]});
        chk("vel", 32'h100, vel);
        chk("busy", 32'h1, {31'h0, busy});
        hm.settle();
        for (int i = 1; i < 3; i++) begin
            hm.pulse_start();
            hm.rd(`STP_ADDR_START, rv);
            chk("skip_cnt", 32'(i), {28'h0, rv[23:20]});
        end
        chk("vel", 32'h100, vel);
        hm.pulse_start();
        chk("strobe", 32'h1, {31'h0, strobe});
        chk("vel", 32'h200, vel);
        chk("jerk1", 32'h203, jerk1);
        chk("jerk4", 32'h206, j4);
        chk("gconf", 32'h77, gconf);
        hm.rd(`STP_ADDR_START, rv);
        chk("skip_cnt", 32'h0, {28'h0, rv[23:20]});
        hm.rd(`STP_ADDR_BACKUP0, rv);
        chk("backup0", 32'h207, rv);
        hm.rd(7'h47, rv);
        chk("backup7", 32'h207, rv);
        $display("shadow double done");
    endtask
    // cyclic: previous active set lands in the second stage
    task automatic t_shadow_cyclic();
        hm.wr(`STP_ADDR_START, 32'h0005_0010);
        hm.settle();
        hm.pulse_start();
        chk("vel", 32'h207, vel);
        hm.rd(7'h47, rv);
        chk("backup7", 32'h200, rv);
        $display("shadow cyclic done");
    endtask

    initial begin
        repeat (6) @(negedge clk_i);
        reset_i = 1'b0;
        chk("target", 32'h0, tgt);
        t_queue_target();
        t_queue_map();
        t_shadow_double();
        t_shadow_cyclic();
        end_of_test();
    end
    // run needs about 1100 cycles, cut a hang at ten thousand
    initial begin
        #40000;
        bad_count++;
        end_of_test();
    end
endmodule // stp_shadow_target_tb
